// File: logic/exc_pkg.sv
// shared constants and types for the exception unit
package exc_pkg;
    // fetch targets
    localparam logic [31:0] RESET_VECTOR    = 32'hbfc0_0000;
    localparam logic [31:0] GEN_VECTOR      = 32'h8000_0080;
    localparam logic [31:0] BOOT_GEN_VECTOR = 32'hbfc0_0180;
    // instruction fields and encodings
    localparam int          OPC_MSB     = 31;
    localparam int          OPC_LSB     = 26;
    localparam int          FN_MSB      = 5;
    localparam int          FN_LSB      = 0;
    localparam logic [5:0]  OP_SPECIAL  = 6'h00;
    localparam logic [5:0]  OP_ADDI     = 6'h08;
    localparam logic [5:0]  OP_SUBI     = 6'h18;
    localparam logic [5:0]  FN_ADD      = 6'h20;
    localparam logic [5:0]  FN_SUB      = 6'h22;
    localparam logic [5:0]  FN_SYSCALL  = 6'h0c;
    // one bit per major / minor code that the core implements
    localparam logic [63:0] OP_DEFINED  = 64'h0100_ffff_ff3f_ffff;
    localparam logic [63:0] FN_DEFINED  = 64'h0000_00ff_0f0f_3fdd;
    // cause codes
    localparam logic [4:0]  OVERFLOW_CAUSE_CODE       = 5'h0c;
    localparam logic [4:0]  RESERVED_INSTR_CAUSE_CODE = 5'h0a;
    localparam logic [4:0]  SYSCALL_CAUSE_CODE        = 5'h08;
    // status / cause field positions
    localparam int          IE_C_BIT   = 0;
    localparam int          KU_C_BIT   = 1;
    localparam int          SWC_BIT    = 17;
    localparam int          TS_BIT     = 21;
    localparam int          BEV_BIT    = 22;
    localparam int          BD_BIT     = 31;
    localparam int          CODE_LSB   = 2;
    localparam int          CODE_MSB   = 6;
    localparam logic [31:0] STATUS_WMASK = 32'h0062_003f;
    localparam logic [31:0] STATUS_RST   = 32'h0060_0000;
    localparam int          LOCK_BIT     = 31;
    // reset values of configuration and timer registers
    localparam logic [31:0] CACHE_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] BUS_CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] COUNT_RST     = 32'h0000_0000;
    localparam logic [31:0] COMPARE_RST   = 32'hffff_ffff;
    // register byte offsets
    localparam logic [7:0]  A_STATUS   = 8'h00;
    localparam logic [7:0]  A_CAUSE    = 8'h04;
    localparam logic [7:0]  A_EPC      = 8'h08;
    localparam logic [7:0]  A_COUNT    = 8'h0c;
    localparam logic [7:0]  A_COMPARE  = 8'h10;
    localparam logic [7:0]  A_CACHECFG = 8'h14;
    localparam logic [7:0]  A_PORTW    = 8'h18;
    localparam logic [7:0]  A_BUS_CONTROL_REG  = 8'h1c;
    localparam logic [7:0]  A_EVSTAT   = 8'h20;
    localparam logic [7:0]  A_EVMASK   = 8'h24;
    // event bits
    localparam int          EV_W   = 5;
    localparam int          EV_OVF = 0;
    localparam int          EV_RI  = 1;
    localparam int          EV_SYS = 2;
    localparam int          EV_RST = 3;
    localparam int          EV_TMR = 4;

    typedef enum logic [2:0]
    {
        ST_RESET = 3'b001,
        ST_RUN   = 3'b010,
        ST_FLUSH = 3'b100
    } state_t;
endpackage : exc_pkg

// File: logic/exc_if.sv
// signals between the exception core, its decoder and its timer
`timescale 1ns/1ps
interface exc_if;
    logic [31:0] instr;
    logic [31:0] op_a;
    logic [31:0] op_b;
    logic        valid;
    logic        is_ovf;
    logic        is_ri;
    logic        is_sys;
    logic        cnt_we;
    logic        cmp_we;
    logic [31:0] wdata;
    logic [31:0] count;
    logic [31:0] compare;
    logic        match;
    modport dec (input instr, op_a, op_b, valid, output is_ovf, is_ri, is_sys);
    modport tmr (input cnt_we, cmp_we, wdata, output count, compare, match);
    modport core (output instr, op_a, op_b, valid, cnt_we, cmp_we, wdata,
                  input is_ovf, is_ri, is_sys, count, compare, match);
endinterface : exc_if

// File: logic/exc_decode.sv
// instruction classifier: overflow, reserved and system call detection
`timescale 1ns/1ps
module exc_decode
(
    exc_if.dec d
);
    function automatic logic signed_ovf(input logic [31:0] a, input logic [31:0] b, input logic sub);
        logic [31:0] r;
        r = sub ? a - b : a + b;
        return ((a[31] ^ b[31]) == sub) && (r[31] != a[31]);
    endfunction : signed_ovf

    logic [5:0] opc;
    logic [5:0] fn;
    logic       is_add;
    logic       is_sub;
    assign opc = d.instr[exc_pkg::OPC_MSB:exc_pkg::OPC_LSB];
    assign fn  = d.instr[exc_pkg::FN_MSB:exc_pkg::FN_LSB];
    // immediates arrive already sign extended on op_b
    assign is_add = (opc == exc_pkg::OP_ADDI) || (opc == exc_pkg::OP_SPECIAL && fn == exc_pkg::FN_ADD);
    assign is_sub = (opc == exc_pkg::OP_SUBI) || (opc == exc_pkg::OP_SPECIAL && fn == exc_pkg::FN_SUB);
    assign d.is_ovf = d.valid && ((is_add && signed_ovf(d.op_a, d.op_b, 1'b0))
                               || (is_sub && signed_ovf(d.op_a, d.op_b, 1'b1)));
    assign d.is_ri  = d.valid && (!exc_pkg::OP_DEFINED[opc]
                               || (opc == exc_pkg::OP_SPECIAL && !exc_pkg::FN_DEFINED[fn]));
    assign d.is_sys = d.valid && opc == exc_pkg::OP_SPECIAL && fn == exc_pkg::FN_SYSCALL;
endmodule : exc_decode

// File: logic/exc_timer.sv
// free-running count and compare registers
`timescale 1ns/1ps
module exc_timer
(
    input  wire logic clk,
    input  wire logic rst_n,
    exc_if.tmr        t
);
    logic [31:0] count_reg;
    logic [31:0] compare_reg;
    logic        match_reg;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            count_reg <= exc_pkg::COUNT_RST;
        else if (t.cnt_we)
            count_reg <= t.wdata;
        else
            count_reg <= count_reg + 32'h0000_0001;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            compare_reg <= exc_pkg::COMPARE_RST;
        else if (t.cmp_we)
            compare_reg <= t.wdata;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            match_reg <= 1'b0;
        else
            match_reg <= (count_reg == compare_reg);
    end

    assign t.count   = count_reg;
    assign t.compare = compare_reg;
    assign t.match   = match_reg;

    a_count_reset : assert property (@(posedge clk) !rst_n |=> count_reg == 32'h0000_0000)
        else $error("count not cleared by reset");
    a_cmp_reset : assert property (@(posedge clk) !rst_n |=> compare_reg == 32'hffff_ffff)
        else $error("compare not all ones after reset");
endmodule : exc_timer

// File: logic/cpu_exception_unit.sv
// exception recognition, status stack, reset state and register access
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
module cpu_exception_unit
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ex_valid,
    input  wire logic [31:0] ex_instr,
    input  wire logic [31:0] ex_pc,
    input  wire logic        ex_delay_slot,
    input  wire logic [31:0] ex_branch_pc,
    input  wire logic [31:0] ex_op_a,
    input  wire logic [31:0] ex_op_b,
    output logic             ex_commit,
    output logic             fetch_redirect,
    output logic      [31:0] fetch_pc,
    input  wire logic [1:0]  boot_width,
    output logic             kernel_mode,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////////
    exc_if bus ();

    exc_decode u_dec
    (
        .d (bus.dec)
    );

    exc_timer u_tmr
    (
        .clk   (clk),
        .rst_n (rst_n),
        .t     (bus.tmr)
    );

    exc_pkg::state_t state_reg;
    logic [31:0]     status_reg;
    logic [31:0]     cause_reg;
    logic [31:0]     exception_pc;
    logic [31:0]     cache_cfg_reg;
    logic [31:0]     memory_port_width_reg;
    logic [31:0]     bus_control_reg;
    logic [exc_pkg::EV_W-1:0] ev_stat_reg;
    logic [exc_pkg::EV_W-1:0] ev_mask_reg;
    logic [exc_pkg::EV_W-1:0] ev_set;
    logic [1:0]      boot_meta_reg;
    logic [1:0]      boot_sync_reg;
    logic            redirect_reg;
    logic [31:0]     redirect_pc_reg;
    logic [31:0]     prdata_reg;
    logic            take_exc;
    logic [4:0]      exc_code;
    logic            setup;
    logic            wr_acc;
    logic            rd_acc;
    logic [31:0]     rd_val;
    logic            addr_hit;

    assign bus.instr = ex_instr;
    assign bus.op_a  = ex_op_a;
    assign bus.op_b  = ex_op_b;
    // nothing is classified while the pipe is still being squashed
    assign bus.valid = ex_valid && state_reg == exc_pkg::ST_RUN;

    ////////////////////////////////////////////////////////////////////////////
    // exception selection
    assign take_exc = bus.is_ovf || bus.is_ri || bus.is_sys;

    always_comb
    begin
        exc_code = exc_pkg::SYSCALL_CAUSE_CODE;
        if (bus.is_ri)
            exc_code = exc_pkg::RESERVED_INSTR_CAUSE_CODE;
        else if (bus.is_ovf)
            exc_code = exc_pkg::OVERFLOW_CAUSE_CODE;
    end

    // the faulting instruction and the one behind it are both held back
    assign ex_commit = ex_valid && state_reg == exc_pkg::ST_RUN && !take_exc;

    ////////////////////////////////////////////////////////////////////////////
    // sequencing: reset release, run, one squash cycle during each redirect
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            state_reg <= exc_pkg::ST_RESET;
        else
            case (state_reg)
                exc_pkg::ST_RESET: state_reg <= exc_pkg::ST_FLUSH;
                exc_pkg::ST_RUN:   state_reg <= take_exc ? exc_pkg::ST_FLUSH : exc_pkg::ST_RUN;
                exc_pkg::ST_FLUSH: state_reg <= exc_pkg::ST_RUN;
                default:           state_reg <= exc_pkg::ST_RESET;
            endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            redirect_reg    <= 1'b0;
            redirect_pc_reg <= exc_pkg::RESET_VECTOR;
        end
        else if (state_reg == exc_pkg::ST_RESET)
        begin
            redirect_reg    <= 1'b1;
            redirect_pc_reg <= exc_pkg::RESET_VECTOR;
        end
        else
        begin
            redirect_reg    <= take_exc;
            redirect_pc_reg <= status_reg[exc_pkg::BEV_BIT] ? exc_pkg::BOOT_GEN_VECTOR : exc_pkg::GEN_VECTOR;
        end
    end

    assign fetch_redirect = redirect_reg;
    assign fetch_pc       = redirect_pc_reg;

    ////////////////////////////////////////////////////////////////////////////
    // apb access
    assign setup   = psel && !penable;
    assign wr_acc  = psel && penable && pwrite && addr_hit;
    assign rd_acc  = psel && penable && !pwrite && addr_hit;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    always_comb
    begin
        rd_val   = 32'h0000_0000;
        addr_hit = 1'b1;
        if (paddr == exc_pkg::A_STATUS)
            rd_val = status_reg;
        else if (paddr == exc_pkg::A_CAUSE)
            rd_val = cause_reg;
        else if (paddr == exc_pkg::A_EPC)
            rd_val = exception_pc;
        else if (paddr == exc_pkg::A_COUNT)
            rd_val = bus.count;
        else if (paddr == exc_pkg::A_COMPARE)
            rd_val = bus.compare;
        else if (paddr == exc_pkg::A_CACHECFG)
            rd_val = cache_cfg_reg;
        else if (paddr == exc_pkg::A_PORTW)
            rd_val = memory_port_width_reg;
        else if (paddr == exc_pkg::A_BUS_CONTROL_REG)
            rd_val = bus_control_reg;
        else if (paddr == exc_pkg::A_EVSTAT)
            rd_val = {{(32-exc_pkg::EV_W){1'b0}}, ev_stat_reg};
        else if (paddr == exc_pkg::A_EVMASK)
            rd_val = {{(32-exc_pkg::EV_W){1'b0}}, ev_mask_reg};
        else
            addr_hit = 1'b0;
    end

    // read data is captured in setup so it stands for the whole access phase
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            prdata_reg <= 32'h0000_0000;
        else if (setup && !pwrite)
            prdata_reg <= rd_val;
    end

    assign prdata = prdata_reg;

    assign bus.wdata  = pwdata;
    assign bus.cnt_we = wr_acc && paddr == exc_pkg::A_COUNT;
    assign bus.cmp_we = wr_acc && paddr == exc_pkg::A_COMPARE;

    ////////////////////////////////////////////////////////////////////////////
    // status: an exception overrides a software write in the same cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            status_reg <= exc_pkg::STATUS_RST;
        else if (take_exc)
            status_reg <= {status_reg[31:6], status_reg[3:0], 2'b00};
        else if (wr_acc && paddr == exc_pkg::A_STATUS)
            status_reg <= (pwdata & exc_pkg::STATUS_WMASK) | (32'h0000_0001 << exc_pkg::TS_BIT);
    end

    assign kernel_mode = !status_reg[exc_pkg::KU_C_BIT];

    // cause and victim pc are left unset by reset; software must not rely on them
    always_ff @(posedge clk)
    begin
        if (take_exc)
        begin
            cause_reg <= {ex_delay_slot, 24'h00_0000, exc_code, 2'b00};
            exception_pc <= ex_delay_slot ? ex_branch_pc : ex_pc;
        end
        else if (wr_acc && paddr == exc_pkg::A_EPC)
            exception_pc <= pwdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers lock once software sets their top bit
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cache_cfg_reg <= exc_pkg::CACHE_CFG_RST;
        else if (wr_acc && paddr == exc_pkg::A_CACHECFG && !cache_cfg_reg[exc_pkg::LOCK_BIT])
            cache_cfg_reg <= pwdata;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            bus_control_reg <= exc_pkg::BUS_CTRL_RST;
        else if (wr_acc && paddr == exc_pkg::A_BUS_CONTROL_REG && !bus_control_reg[exc_pkg::LOCK_BIT])
            bus_control_reg <= pwdata;
    end

    // boot width strap is a pin: two flops, then caught on the release cycle
    always_ff @(posedge clk)
    begin
        boot_meta_reg <= boot_width;
        boot_sync_reg <= boot_meta_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            memory_port_width_reg <= 32'h0000_0000;
        else if (state_reg == exc_pkg::ST_RESET)
            memory_port_width_reg <= {16'h0000, {8{boot_sync_reg}}};
        else if (wr_acc && paddr == exc_pkg::A_PORTW && !memory_port_width_reg[exc_pkg::LOCK_BIT])
            memory_port_width_reg <= pwdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // event status: sticky, cleared by a read, a new event wins over the clear
    always_comb
    begin
        ev_set = '0;
        ev_set[exc_pkg::EV_OVF] = take_exc && bus.is_ovf && !bus.is_ri;
        ev_set[exc_pkg::EV_RI]  = take_exc && bus.is_ri;
        ev_set[exc_pkg::EV_SYS] = take_exc && bus.is_sys && !bus.is_ri && !bus.is_ovf;
        ev_set[exc_pkg::EV_RST] = state_reg == exc_pkg::ST_RESET;
        ev_set[exc_pkg::EV_TMR] = bus.match;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ev_stat_reg <= '0;
        else if (rd_acc && paddr == exc_pkg::A_EVSTAT)
            // only the bits the read reported are cleared; one that arrived in its setup cycle stays pending
            ev_stat_reg <= (ev_stat_reg & ~prdata_reg[exc_pkg::EV_W-1:0]) | ev_set;
        else
            ev_stat_reg <= ev_stat_reg | ev_set;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ev_mask_reg <= '0;
        else if (wr_acc && paddr == exc_pkg::A_EVMASK)
            ev_mask_reg <= pwdata[exc_pkg::EV_W-1:0];
    end

    assign irq = |(ev_stat_reg & ev_mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_ovf_redirect : assert property (bus.is_ovf |=> fetch_redirect && (fetch_pc == exc_pkg::GEN_VECTOR
                                      || fetch_pc == exc_pkg::BOOT_GEN_VECTOR))
        else $error("overflow did not redirect to the general vector");
    a_ovf_code : assert property (bus.is_ovf && !bus.is_ri |=> cause_reg[6:2] == exc_pkg::OVERFLOW_CAUSE_CODE)
        else $error("overflow code not loaded");
    a_ri_code : assert property (bus.is_ri |=> fetch_redirect
                                 && cause_reg[6:2] == exc_pkg::RESERVED_INSTR_CAUSE_CODE)
        else $error("reserved instruction code not loaded");
    a_sys_code : assert property (bus.is_sys && !bus.is_ri && !bus.is_ovf
                                  |=> cause_reg[6:2] == exc_pkg::SYSCALL_CAUSE_CODE)
        else $error("system call code not loaded");
    a_epc_slot : assert property (take_exc |=> exception_pc ==
                                  ($past(ex_delay_slot) ? $past(ex_branch_pc) : $past(ex_pc))
                                  && cause_reg[31] == $past(ex_delay_slot))
        else $error("victim pc or delay flag wrong");
    a_stack_push : assert property (take_exc |=> status_reg[1:0] == 2'b00
                                    && status_reg[5:2] == $past(status_reg[3:0]))
        else $error("status stack not pushed");
    a_no_commit : assert property (take_exc |-> !ex_commit ##1 !ex_commit)
        else $error("excepting or younger instruction committed");
    a_reset_vec : assert property (disable iff (1'b0) $rose(rst_n) |=> fetch_redirect
                                   && fetch_pc == exc_pkg::RESET_VECTOR)
        else $error("reset vector not fetched after release");
    a_reset_hold : assert property (disable iff (1'b0) !rst_n |=> !fetch_redirect)
        else $error("redirect while reset still held");
    a_reset_bits : assert property (disable iff (1'b0) !rst_n |=> status_reg[exc_pkg::SWC_BIT] == 1'b0
                                    && status_reg[1:0] == 2'b00 && status_reg[exc_pkg::BEV_BIT])
        else $error("status reset bits wrong");
    a_ts_frozen : assert property (status_reg[exc_pkg::TS_BIT])
        else $error("translation shutdown bit not held at one");
    a_cfg_unlock : assert property (disable iff (1'b0) !rst_n |=> !cache_cfg_reg[exc_pkg::LOCK_BIT]
                                    && !bus_control_reg[exc_pkg::LOCK_BIT])
        else $error("configuration left locked after reset");
    a_port_width : assert property (rst_n && state_reg == exc_pkg::ST_RESET
                                    |=> memory_port_width_reg[1:0] == $past(boot_sync_reg))
        else $error("port width not loaded from boot width");
    a_squash_slot : assert property (fetch_redirect |-> !ex_commit)
        else $error("instruction committed in the squash cycle");
    // a clearing read must never swallow an event that lands on its access edge
    a_event_keep : assert property (rd_acc && paddr == exc_pkg::A_EVSTAT
                                    |=> (ev_stat_reg & $past(ev_set)) == $past(ev_set))
        else $error("event lost by a clearing read");

    c_ovf_taken : cover property (bus.is_ovf ##1 fetch_redirect);
    c_ri_slot   : cover property (bus.is_ri && ex_delay_slot);
    c_sys_taken : cover property (bus.is_sys ##2 ex_commit);
    c_epc_branch : cover property (take_exc && ex_delay_slot ##1 fetch_redirect);
    c_irq_up    : cover property (disable iff (1'b0) $rose(rst_n) ##[1:20] irq);
endmodule : cpu_exception_unit

// File: tb/pipe_model.sv
// execute-stage pipeline model that feeds one instruction per call
`timescale 1ns/1ps
module pipe_model
(
    output logic        ex_valid,
    output logic [31:0] ex_instr,
    output logic [31:0] ex_pc,
    output logic        ex_delay_slot,
    output logic [31:0] ex_branch_pc,
    output logic [31:0] ex_op_a,
    output logic [31:0] ex_op_b
);
    initial
    begin
        ex_valid = 1'b0;
        {ex_instr, ex_pc, ex_delay_slot, ex_branch_pc, ex_op_a, ex_op_b} = '0;
    end
    task automatic drive(input logic [31:0] i, p, bp, a, b, input logic ds);
        ex_valid      <= 1'b1;
        ex_instr      <= i;
        ex_pc         <= p;
        ex_delay_slot <= ds;
        ex_branch_pc  <= bp;
        ex_op_a       <= a;
        ex_op_b       <= b;
    endtask : drive
    // idle slots carry inverted instruction and operand words so a stale word is never taken for a live one
    task automatic idle();
        ex_valid <= 1'b0;
        ex_instr <= ~ex_instr;
        ex_op_a  <= ~ex_op_a;
        ex_op_b  <= ~ex_op_b;
    endtask : idle
endmodule : pipe_model

// File: tb/tb_top.sv
// self-checking bench for the exception unit
`timescale 1ns/1ps
module tb_top;
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, s, e, a, b, pc, d, bb;
    logic        pready, pslverr, se, ex_commit, fetch_redirect, kernel_mode, irq, ds, m, ov, exc;
    logic        ex_valid, ex_delay_slot;
    logic [31:0] fetch_pc, ex_instr, ex_pc, ex_branch_pc, ex_op_a, ex_op_b;
    logic [1:0]  boot_width = 2'b10;
    logic [4:0]  code;
    int          err_count = 0, n_compared = 0, k;
    logic [31:0] itab [7] = '{{exc_pkg::OP_SPECIAL, 20'h0, exc_pkg::FN_ADD}, {exc_pkg::OP_SPECIAL, 20'h0,
        exc_pkg::FN_SUB}, {exc_pkg::OP_ADDI, 26'h0}, {exc_pkg::OP_SUBI, 26'h0}, {exc_pkg::OP_SPECIAL, 20'h0,
        exc_pkg::FN_SYSCALL}, {6'h16, 26'h0}, {exc_pkg::OP_SPECIAL, 20'h0, 6'h01}};
    cpu_exception_unit DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ex_valid(ex_valid), .ex_instr(ex_instr), .ex_pc(ex_pc), .ex_delay_slot(ex_delay_slot),
        .ex_branch_pc(ex_branch_pc), .ex_op_a(ex_op_a), .ex_op_b(ex_op_b), .ex_commit(ex_commit),
        .fetch_redirect(fetch_redirect), .fetch_pc(fetch_pc), .boot_width(boot_width),
        .kernel_mode(kernel_mode), .irq(irq));
    pipe_model u_pipe (.ex_valid(ex_valid), .ex_instr(ex_instr), .ex_pc(ex_pc), .ex_delay_slot(ex_delay_slot),
        .ex_branch_pc(ex_branch_pc), .ex_op_a(ex_op_a), .ex_op_b(ex_op_b));
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // no fixed wait state assumed; the watchdog bounds this loop
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic end_sim();
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #500000;
        err_count++;
        end_sim();
    end
    initial
    begin
        void'($urandom(32'hda6f_ae08));
        repeat (8) @(posedge clk);
        chk("redirect in reset", {31'h0, fetch_redirect}, 32'h0);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("reset redirect", {31'h0, fetch_redirect}, 32'h1);
        chk("reset vector", fetch_pc, exc_pkg::RESET_VECTOR);
        @(posedge clk);
        apb(1'b0, exc_pkg::A_STATUS, 0);
        chk("status", rd, 32'h1 << exc_pkg::BEV_BIT | 32'h1 << exc_pkg::TS_BIT);
        apb(1'b0, exc_pkg::A_COMPARE, 0);
        chk("compare", rd, 32'hffff_ffff);
        apb(1'b0, exc_pkg::A_COUNT, 0);
        chk("count", {31'h0, rd < 32'h0000_0010}, 32'h1);
        apb(1'b0, exc_pkg::A_CACHECFG, 0);
        chk("cache cfg", rd, exc_pkg::CACHE_CFG_RST);
        apb(1'b0, exc_pkg::A_PORTW, 0);
        chk("port width", rd, {16'h0, {8{boot_width}}});
        apb(1'b0, exc_pkg::A_BUS_CONTROL_REG, 0);
        chk("bus ctrl", rd, exc_pkg::BUS_CTRL_RST);
        apb(1'b0, exc_pkg::A_EVSTAT, 0);
        chk("reset event", rd, 32'h1 << exc_pkg::EV_RST);
        apb(1'b0, 8'h40, 0);
        chk("unmapped err", {31'h0, se}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, exc_pkg::A_EVMASK, 32'h0000_0007);
        for (int i = 0; i < 42; i++)
        begin
            k = i % 7;
            a = $urandom;
            b = $urandom;
            ds = 1'($urandom);
            pc = $urandom & 32'hffff_fffc;
            s = $urandom & 32'h0040_003f;
            m = (k == 1 || k == 3);
            bb = m ? ~b : b;
            d = a + bb + 32'(m);
            ov = k < 4 && a[31] == bb[31] && d[31] != a[31];
            exc = k >= 4 || ov;
            code = k > 4 ? exc_pkg::RESERVED_INSTR_CAUSE_CODE : k == 4 ? exc_pkg::SYSCALL_CAUSE_CODE
                 : exc_pkg::OVERFLOW_CAUSE_CODE;
            apb(1'b1, exc_pkg::A_STATUS, s);
            u_pipe.drive(itab[k], pc, pc - 32'h4, a, b, ds);
            @(negedge clk);
            chk("commit", {31'h0, ex_commit}, {31'h0, !exc});
            @(posedge clk);
            u_pipe.idle();
            @(negedge clk);
            chk("redirect", {31'h0, fetch_redirect}, {31'h0, exc});
            if (exc)
                chk("vector", fetch_pc, s[22] ? exc_pkg::BOOT_GEN_VECTOR : exc_pkg::GEN_VECTOR);
            @(posedge clk);
            e = exc ? (s & 32'hffff_ffc0) | {26'h0, s[3:0], 2'b00} : s;
            apb(1'b0, exc_pkg::A_STATUS, 0);
            chk("status", rd, e | 32'h0020_0000);
            chk("kernel", {31'h0, kernel_mode}, {31'h0, !e[1]});
            if (exc)
            begin
                chk("irq set", {31'h0, irq}, 32'h1);
                apb(1'b0, exc_pkg::A_CAUSE, 0);
                chk("cause", rd & 32'h8000_007c, {ds, 24'h0, code, 2'b00});
                apb(1'b0, exc_pkg::A_EPC, 0);
                chk("epc", rd, ds ? pc - 32'h4 : pc);
                apb(1'b0, exc_pkg::A_EVSTAT, 0);
                chk("event", rd, k > 4 ? 32'h2 : k == 4 ? 32'h4 : 32'h1);
                chk("irq clear", {31'h0, irq}, 32'h0);
            end
            else
                chk("irq idle", {31'h0, irq}, 32'h0);
        end
        apb(1'b1, exc_pkg::A_COUNT, 32'h0000_0100);
        apb(1'b0, exc_pkg::A_COUNT, 0);
        chk("count run", rd, 32'h0000_0101);
        apb(1'b1, exc_pkg::A_CACHECFG, 32'h8000_00a5);
        apb(1'b1, exc_pkg::A_CACHECFG, 32'h0000_0001);
        apb(1'b0, exc_pkg::A_CACHECFG, 0);
        chk("cfg locked", rd, 32'h8000_00a5);
        // second reset in mid-run: lock and status stack must return to their reset state
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        apb(1'b0, exc_pkg::A_CACHECFG, 0);
        chk("cfg after reset", rd, exc_pkg::CACHE_CFG_RST);
        apb(1'b0, exc_pkg::A_STATUS, 0);
        chk("status after reset", rd, 32'h1 << exc_pkg::BEV_BIT | 32'h1 << exc_pkg::TS_BIT);
        end_sim();
    end
endmodule : tb_top
